// *** src/twb_map.svh ***
// Register map, field positions, reset values and timing counts for
// the two-wire bus port. Included by the core; holds definitions only.
`ifndef TWB_MAP_SVH
`define TWB_MAP_SVH

`define TWB_OFF_CTRL1 8'h00
`define TWB_OFF_CTRL2 8'h04
`define TWB_OFF_MODE 8'h08
`define TWB_OFF_IER 8'h0c
`define TWB_OFF_STAT 8'h10
`define TWB_OFF_OAF 8'h14
`define TWB_OFF_TXH 8'h18
`define TWB_OFF_RXH 8'h1c

`define TWB_C1_IFEN 7
`define TWB_C1_MSEL 5
`define TWB_C1_TSEL 4
`define TWB_C2_BUSY 7
`define TWB_C2_STRB 6
`define TWB_MD_BITREV 3
`define TWB_IE_ACKCHK 2
`define TWB_IE_RACK 0
`define TWB_OAF_FMT 0

`define TWB_ST_TXE 7
`define TWB_ST_TXEND 6
`define TWB_ST_RXFULL 5
`define TWB_ST_NACK 4
`define TWB_ST_STOP 3
`define TWB_ST_AL 2
`define TWB_ST_MATCH 1
`define TWB_ST_GCALL 0

`define TWB_RST_OAF 8'h00
`define TWB_RST_TXH 8'hff
`define TWB_RST_RXH 8'hff
`define TWB_GCALL_ADDR 8'h00

`define TWB_CLK_NS 100
`define TWB_QTR_NS 2500
`define TWB_QTR_CYC ((`TWB_QTR_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)

`endif

// *** src/twb_pkg.sv ***
// State types of the two-wire bus port.
// Assumes the map header supplies all numeric constants.
package twb_pkg;
  typedef enum logic [5:0] {
    M_IDLE = 6'h01, M_START = 6'h02, M_WAIT = 6'h04,
    M_BIT = 6'h08, M_ACK = 6'h10, M_STOP = 6'h20
  } twb_mst_t;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_ADDR = 6'h02, S_ACKW = 6'h04,
    S_ACKH = 6'h08, S_DATA = 6'h10, S_SKIP = 6'h20
  } twb_slv_t;
endpackage : twb_pkg

// *** src/twb_core.sv ***
// Two-wire bus port: AXI4-Lite registers, master transmit, slave receive.
// Assumes open-drain pads outside resolve scl/sda from the enables.
`timescale 1ns/10ps
`include "twb_map.svh"

module twb_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = v[7-i];
    end
  endfunction : rev8

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_full, w_full;
  logic [7:0] aw_q;
  logic [7:0] wd_q;
  logic wl_q;
  logic ifen, msel, tsel, bitrev, ackchk, rack;
  logic [7:0] oaf, txh, rxh, flags, seen;
  logic bus_busy;
  twb_pkg::twb_mst_t mstate;
  twb_pkg::twb_slv_t sstate;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;

  logic do_wr, do_rd, wr_map, rd_map;
  assign do_wr = aw_full && w_full && !s_axi_bvalid;
  assign do_rd = s_axi_arvalid && !s_axi_rvalid;
  assign wr_map = (aw_q[7:2] <= `TWB_OFF_RXH >> 2);
  assign rd_map = (s_axi_araddr[7:2] <= `TWB_OFF_RXH >> 2);

  // Write strobes per register, low byte lane only
  logic wr_c1, wr_c2, wr_md, wr_ie, wr_st, wr_oaf, wr_txh;
  assign wr_c1 = do_wr && wl_q && hit(aw_q, `TWB_OFF_CTRL1);
  assign wr_c2 = do_wr && wl_q && hit(aw_q, `TWB_OFF_CTRL2);
  assign wr_md = do_wr && wl_q && hit(aw_q, `TWB_OFF_MODE);
  assign wr_ie = do_wr && wl_q && hit(aw_q, `TWB_OFF_IER);
  assign wr_st = do_wr && wl_q && hit(aw_q, `TWB_OFF_STAT);
  assign wr_oaf = do_wr && wl_q && hit(aw_q, `TWB_OFF_OAF);
  assign wr_txh = do_wr && wl_q && hit(aw_q, `TWB_OFF_TXH);

  // Address and data captured independently, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 8'h00;
      wl_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        wd_q <= s_axi_wdata[7:0];
        wl_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; shift register is never visible here
  // receive holding read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
      s_axi_rdata <= 32'h0;
      case (s_axi_araddr[7:2])
        6'h00: s_axi_rdata[7:0] <= {ifen, 1'b0, msel, tsel, 4'h0};
        6'h01: s_axi_rdata[7:0] <= {bus_busy, 7'h00};
        6'h02: s_axi_rdata[7:0] <= {4'h0, bitrev, 3'h0};
        6'h03: s_axi_rdata[7:0] <= {5'h00, ackchk, 1'b0, rack};
        6'h04: s_axi_rdata[7:0] <= flags;
        6'h05: s_axi_rdata[7:0] <= oaf;
        6'h06: s_axi_rdata[7:0] <= bitrev ? rev8(txh) : txh;
        6'h07: s_axi_rdata[7:0] <= rxh;
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  logic stop_det, start_det, mst_done;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ifen <= 1'b0;
      msel <= 1'b0;
      tsel <= 1'b0;
      bitrev <= 1'b0;
      ackchk <= 1'b0;
      oaf <= `TWB_RST_OAF;
      txh <= `TWB_RST_TXH;
    end else begin
      if (wr_c1) begin
        ifen <= wd_q[`TWB_C1_IFEN];
        msel <= wd_q[`TWB_C1_MSEL];
        tsel <= wd_q[`TWB_C1_TSEL];
      end
      if (mst_done) begin
        msel <= 1'b0;
        tsel <= 1'b0;
      end
      if (wr_md) bitrev <= wd_q[`TWB_MD_BITREV];
      if (wr_ie) ackchk <= wd_q[`TWB_IE_ACKCHK];
      if (wr_oaf) oaf <= wd_q;
      if (wr_txh) txh <= wd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  logic scl_rise, scl_fall;
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // Bus busy tracks start and stop seen on the wires
  always_ff @(posedge aclk) begin
    if (!aresetn) bus_busy <= 1'b0;
    else if (start_det) bus_busy <= 1'b1;
    else if (stop_det) bus_busy <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Quarter-bit tick divider for the master clock
  logic [7:0] div;
  logic tick;
  assign tick = (div == 8'(`TWB_QTR_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) div <= 8'h00;
    else div <= div + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Master transmit engine
  logic [1:0] phase;
  logic [2:0] mbit;
  logic [7:0] tx_shift;
  logic shift_full, txh_pend, start_pend, stop_pend;
  logic m_scl_low, m_sda_low, txe;
  logic ev_transmit_end_flag, ev_nack, ev_al, ev_sent;
  logic start_req, stop_req, load;
  assign start_req = wr_c2 && wd_q[`TWB_C2_BUSY] && !wd_q[`TWB_C2_STRB];
  assign stop_req = wr_c2 && !wd_q[`TWB_C2_BUSY] && !wd_q[`TWB_C2_STRB];
  assign load = txh_pend && !shift_full && msel && tsel && ifen;
  assign mst_done = stop_det && (mstate == twb_pkg::M_STOP);

  // Holding register pending marker; bytes written outside master
  // transmit are dropped so a stale byte is never sent after a start
  always_ff @(posedge aclk) begin
    if (!aresetn) txh_pend <= 1'b0;
    else if (wr_txh) txh_pend <= 1'b1;
    else if (load || !(msel && tsel)) txh_pend <= 1'b0;
  end

  // Start/stop requests wait for the engine to take them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_pend <= 1'b0;
      stop_pend <= 1'b0;
    end else begin
      if (start_req && msel && tsel) start_pend <= 1'b1;
      else if (mstate == twb_pkg::M_START || !msel) start_pend <= 1'b0;
      if (stop_req) stop_pend <= 1'b1;
      else if (mstate == twb_pkg::M_STOP || !msel) stop_pend <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mstate <= twb_pkg::M_IDLE;
      phase <= 2'h0;
      mbit <= 3'h0;
      tx_shift <= 8'h00;
      shift_full <= 1'b0;
      m_scl_low <= 1'b0;
      m_sda_low <= 1'b0;
      rack <= 1'b0;
      {ev_transmit_end_flag, ev_nack, ev_al, ev_sent} <= 4'h0;
    end else begin
      {ev_transmit_end_flag, ev_nack, ev_al, ev_sent} <= 4'h0;
      if (load) begin
        tx_shift <= bitrev ? rev8(txh) : txh;
        shift_full <= 1'b1;
      end
      if (tick) begin
        phase <= phase + 2'h1;
        case (mstate)
          twb_pkg::M_IDLE: begin
            phase <= 2'h0;
            m_scl_low <= 1'b0;
            m_sda_low <= 1'b0;
            if (start_pend && !bus_busy && ifen) mstate <= twb_pkg::M_START;
          end
          twb_pkg::M_START: begin
            if (phase == 2'h1) m_sda_low <= 1'b1;
            if (phase == 2'h3) begin
              m_scl_low <= 1'b1;
              mstate <= twb_pkg::M_WAIT;
            end
          end
          twb_pkg::M_WAIT: begin
            phase <= 2'h0;
            m_scl_low <= 1'b1;
            if (stop_pend) begin
              mstate <= twb_pkg::M_STOP;
            end else if (shift_full) begin
              mbit <= 3'h0;
              mstate <= twb_pkg::M_BIT;
            end
          end
          twb_pkg::M_BIT: begin
            if (phase == 2'h0) m_sda_low <= !tx_shift[7];
            if (phase == 2'h1) m_scl_low <= 1'b0;
            if (phase == 2'h2 && !m_sda_low && !sda_s2) begin
              ev_al <= 1'b1;
              m_sda_low <= 1'b0;
              shift_full <= 1'b0;
              mstate <= twb_pkg::M_IDLE;
            end
            if (phase == 2'h3) begin
              m_scl_low <= 1'b1;
              tx_shift <= {tx_shift[6:0], 1'b0};
              mbit <= mbit + 3'h1;
              if (mbit == 3'h7) mstate <= twb_pkg::M_ACK;
            end
          end
          twb_pkg::M_ACK: begin
            if (phase == 2'h0) m_sda_low <= 1'b0;
            if (phase == 2'h1) begin
              m_scl_low <= 1'b0;
              ev_transmit_end_flag <= txe;
            end
            if (phase == 2'h2) begin
              rack <= sda_s2;
              ev_nack <= sda_s2 && ackchk;
            end
            if (phase == 2'h3) begin
              m_scl_low <= 1'b1;
              shift_full <= 1'b0;
              ev_sent <= 1'b1;
              mstate <= twb_pkg::M_WAIT;
            end
          end
          twb_pkg::M_STOP: begin
            if (phase == 2'h0) m_sda_low <= 1'b1;
            if (phase == 2'h1) m_scl_low <= 1'b0;
            if (phase == 2'h2) m_sda_low <= 1'b0;
            if (phase == 2'h3) mstate <= twb_pkg::M_IDLE;
          end
          default: mstate <= twb_pkg::M_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave receive engine; clocked serial format is not handled here
  logic [7:0] rx_shift, nb;
  logic [2:0] sbit;
  logic s_sda_low, s_rw, s_addressed, ev_match, ev_gc, ev_rx;
  logic slv_on;
  assign slv_on = ifen && !msel && !oaf[`TWB_OAF_FMT];
  assign nb = {rx_shift[6:0], sda_s2};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sstate <= twb_pkg::S_IDLE;
      rx_shift <= 8'h00;
      sbit <= 3'h0;
      s_sda_low <= 1'b0;
      s_rw <= 1'b0;
      s_addressed <= 1'b0;
      rxh <= `TWB_RST_RXH;
      {ev_match, ev_gc, ev_rx} <= 3'h0;
    end else begin
      {ev_match, ev_gc, ev_rx} <= 3'h0;
      if (!slv_on || stop_det) begin
        sstate <= twb_pkg::S_IDLE;
        s_sda_low <= 1'b0;
        if (stop_det) s_addressed <= 1'b0;
      end else if (start_det) begin
        sstate <= twb_pkg::S_ADDR;
        sbit <= 3'h0;
        s_sda_low <= 1'b0;
      end else begin
        case (sstate)
          twb_pkg::S_ADDR, twb_pkg::S_DATA: begin
            if (scl_rise) begin
              rx_shift <= nb;
              sbit <= sbit + 3'h1;
              if (sbit == 3'h7) begin
                sstate <= twb_pkg::S_ACKW;
                if (sstate == twb_pkg::S_DATA) begin
                  rxh <= bitrev ? rev8(nb) : nb;
                  ev_rx <= 1'b1;
                end else if (nb[7:1] == oaf[7:1] || nb == `TWB_GCALL_ADDR) begin
                  // Foreign frames leave the holding register alone
                  rxh <= bitrev ? rev8(nb) : nb;
                  ev_rx <= 1'b1;
                  ev_match <= 1'b1;
                  ev_gc <= (nb == `TWB_GCALL_ADDR);
                  s_rw <= nb[0];
                  s_addressed <= 1'b1;
                end else begin
                  sstate <= twb_pkg::S_SKIP;
                end
              end
            end
          end
          twb_pkg::S_ACKW: begin
            if (scl_fall) begin
              s_sda_low <= 1'b1;
              sstate <= twb_pkg::S_ACKH;
            end
          end
          twb_pkg::S_ACKH: begin
            if (scl_fall) begin
              s_sda_low <= 1'b0;
              sbit <= 3'h0;
              sstate <= s_rw ? twb_pkg::S_SKIP : twb_pkg::S_DATA;
            end
          end
          twb_pkg::S_IDLE, twb_pkg::S_SKIP: sstate <= sstate;
          default: sstate <= twb_pkg::S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over a software clear in the same cycle, except a TXH write, which clears txe over a load
  logic txend, rxfull, nack, stopf, al, match, gc;
  logic rd_st, rd_rxh;
  logic [7:0] clr;
  assign rd_st = do_rd && hit(s_axi_araddr, `TWB_OFF_STAT);
  assign rd_rxh = do_rd && hit(s_axi_araddr, `TWB_OFF_RXH);
  // clear needs prior read of 1
  assign clr = wr_st ? (~wd_q & seen) : 8'h00;
  assign flags = {txe, txend, rxfull, nack, stopf, al, match, gc};

  // Flags seen as 1 by a status read arm the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) seen <= 8'h00;
    else if (rd_st) seen <= flags;
    else if (wr_st) seen <= 8'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {txe, txend, rxfull, nack, stopf, al, match, gc} <= 8'h00;
    end else begin
      if (wr_txh) txe <= 1'b0;
      else if (load || (start_req && msel && tsel)) txe <= 1'b1;
      else if (clr[`TWB_ST_TXE]) txe <= 1'b0;
      if (ev_transmit_end_flag) txend <= 1'b1;
      else if (clr[`TWB_ST_TXEND] || wr_txh) txend <= 1'b0;
      if (ev_rx) rxfull <= 1'b1;
      else if (clr[`TWB_ST_RXFULL] || rd_rxh) rxfull <= 1'b0;
      if (ev_nack) nack <= 1'b1;
      else if (clr[`TWB_ST_NACK]) nack <= 1'b0;
      if (mst_done || (stop_det && s_addressed)) stopf <= 1'b1;
      else if (clr[`TWB_ST_STOP]) stopf <= 1'b0;
      if (ev_al) al <= 1'b1;
      else if (clr[`TWB_ST_AL]) al <= 1'b0;
      if (ev_match) match <= 1'b1;
      else if (clr[`TWB_ST_MATCH]) match <= 1'b0;
      if (ev_gc) gc <= 1'b1;
      else if (clr[`TWB_ST_GCALL]) gc <= 1'b0;
    end
  end

  // Open-drain pads: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = m_scl_low;
  assign sda_oe = m_sda_low || s_sda_low;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_load_txe;
    load && !wr_txh |=> txe && shift_full;
  endproperty
  a_load_txe: assert property (p_load_txe) else $error("load no txe");
  property p_wr_txe;
    wr_txh |=> !txe;
  endproperty
  a_wr_txe: assert property (p_wr_txe) else $error("txe kept");
  property p_rev;
    do_rd && hit(s_axi_araddr, `TWB_OFF_TXH) && bitrev
      |=> s_axi_rdata[7:0] == rev8($past(txh));
  endproperty
  a_rev: assert property (p_rev) else $error("bad reverse");
  property p_match_hold;
    match && !ev_match && !clr[`TWB_ST_MATCH] |=> match;
  endproperty
  a_match_hold: assert property (p_match_hold) else $error("match lost");
  property p_rxh_src;
    $changed(rxh) |-> ev_rx;
  endproperty
  a_rxh_src: assert property (p_rxh_src) else $error("rxh changed");
  property p_hold_low;
    mstate == twb_pkg::M_WAIT ##1 mstate == twb_pkg::M_WAIT |-> scl_oe;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("scl free");
  property p_transmit_end_flag;
    ev_transmit_end_flag |-> mstate == twb_pkg::M_ACK ##1 txend;
  endproperty
  a_transmit_end_flag: assert property (p_transmit_end_flag) else $error("no transmit_end_flag");
  property p_nack;
    ev_nack |=> nack && rack;
  endproperty
  a_nack: assert property (p_nack) else $error("no nack");
  property p_al;
    ev_al |=> al && mstate == twb_pkg::M_IDLE && !sda_oe[*2];
  endproperty
  a_al: assert property (p_al) else $error("no al");
  property p_gc;
    ev_gc |-> ev_match;
  endproperty
  a_gc: assert property (p_gc) else $error("gc alone");
  property p_ret;
    mst_done |=> !msel && !tsel && stopf;
  endproperty
  a_ret: assert property (p_ret) else $error("no return");
  property p_ack;
    sstate == twb_pkg::S_ACKH |-> sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");

  c_sent: cover property (ev_transmit_end_flag ##[1:60] ev_sent);
  c_match: cover property (ev_match);
  c_stop: cover property (mst_done);

endmodule : twb_core

// *** tb/twb_peer.sv ***
// Slave model on the wire pair: acks each byte while ack_en is set, keeps the last one.
// Assumes the bench resolves both pulled-up lines from all pulls.
`timescale 1ns/10ps
module twb_peer (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  output logic sda_pull,
  output logic [7:0] last_byte
);
  int n = 0;
  logic [7:0] sh = 8'h00;
  initial sda_pull = 1'b0;
  always @(negedge sda) if (scl) n = 0;
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    n = n + 1;
  end
  always @(negedge scl) begin
    if (n == 8) last_byte = sh;
    sda_pull = (n == 8) && ack_en;
    if (n == 9) n = 0;
  end
endmodule : twb_peer

// *** tb/twb_core_test.sv ***
// Bench for the two-wire port: registers, slave receive, master send.
// Assumes pull-ups on both lines and one slave model on them.
`timescale 1ns/10ps
module twb_core_test;
  logic aclk, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, m_scl = 0, m_sda = 0, ack_en = 0;
  logic [7:0] awaddr = 0, araddr = 0, d, prev, got;
  logic [31:0] wdata = 0, rdata, seed = 32'd24;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, pull;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_q[$];
  logic [7:0] tab[4] = '{8'h54, 8'h00, 8'h56, 8'h55};
  logic [7:0] stab[4] = '{8'h0a, 8'h0b, 8'h00, 8'h0a};
  int failures = 0, total_checks = 0, cyc = 0;
  // Open-drain lines, high unless someone pulls
  wire scl = !(scl_oe | m_scl);
  wire sda = !(sda_oe | m_sda | pull);
  twb_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe));
  twb_peer peer (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_pull(pull),
    .last_byte(got));
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict();
    // A read whose answer never came counts against the run
    if (exp_q.size() != 0) failures++;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Write holds each channel until its own ready
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r = 2'b00);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (awvalid || wvalid || !bvalid);
    chk({32'h0, bresp}, {32'h0, r});
    bready <= 0;
    // Let an edge pass so the next call does not reassign
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] r = 2'b00);
    exp_q.push_back({r, 24'h0, e});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    @(posedge aclk);
  endtask : rd
  // One quarter of an 800 ns bit
  task automatic q();
    repeat (2) @(posedge aclk);
  endtask : q
  task automatic send(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= -1; i--) begin
      m_sda <= (i >= 0) & !b[7];
      b = b << 1;
      q();
      m_scl <= 0;
      q();
      if (i < 0) chk({33'h0, sda}, {33'h0, !ack});
      q();
      m_scl <= 1;
      q();
    end
  endtask : send
  task automatic xfer(input logic [7:0] a, input logic [7:0] b,
                      input logic ack);
    m_sda <= 1;
    q();
    m_scl <= 1;
    send(a, ack);
    // Read direction: data byte is not taken by the port
    send(b, ack && !a[0]);
    m_sda <= 1;
    q();
    m_scl <= 0;
    q();
    m_sda <= 0;
    q();
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////
  // Result watcher, also the hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h14, 8'h00);
    rd(8'h18, 8'hff);
    wr(8'h1c, 8'h5a);
    rd(8'h1c, 8'hff);
    rd(8'h20, 8'h00, 2'b10);
    wr(8'h20, 8'h00, 2'b10);
    d = rnd();
    prev = {<<{d}};
    wr(8'h08, 8'h08);
    wr(8'h18, d);
    rd(8'h18, prev);
    wr(8'h08, 8'h00);
    wr(8'h14, 8'h54);
    wr(8'h00, 8'h80);
    // Own address, general call, foreign address, own address read
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      xfer(tab[k], d, k != 2);
      if (k == 2) d = prev;
      if (k == 3) d = tab[3];
      rd(8'h1c, d);
      prev = d;
      rd(8'h10, stab[k]);
      wr(8'h10, 8'hff);
      rd(8'h10, stab[k]);
      wr(8'h10, 8'h00);
      rd(8'h10, 8'h00);
    end
    ack_en <= 1;
    wr(8'h00, 8'hb0);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'h80);
    d = rnd() | 8'h80;
    wr(8'h18, d);
    wait (peer.n == 9);
    repeat (60) @(posedge aclk);
    chk({33'h0, scl}, 34'h0);
    chk({26'h0, got}, {26'h0, d});
    rd(8'h10, 8'hc0);
    rd(8'h0c, 8'h00);
    // Second byte goes unanswered with acknowledge checking on
    ack_en <= 0;
    wr(8'h0c, 8'h04);
    d = rnd();
    wr(8'h18, d);
    wait (peer.n == 9);
    repeat (60) @(posedge aclk);
    chk({26'h0, got}, {26'h0, d});
    rd(8'h10, 8'hd0);
    rd(8'h0c, 8'h05);
    wr(8'h04, 8'h00);
    @(posedge sda iff scl);
    repeat (10) @(posedge aclk);
    rd(8'h10, 8'hd8);
    rd(8'h00, 8'h80);
    give_verdict();
  end
endmodule : twb_core_test
